/* File: src/tds_pkg.sv */
// package for the touch detect sequencer: timing, thresholds and carriers
`default_nettype none
package tds_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FAST_GAP_US = 1000;
  localparam int unsigned SLEEP_GAP_US = 80_000;
  localparam int unsigned ALIVE_US = 15;
  localparam int unsigned SYNC_PULSE_MIN_US = 10;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned FAST_GAP_CYC = FAST_GAP_US * CYC_PER_US;
  localparam int unsigned SLEEP_GAP_CYC = SLEEP_GAP_US * CYC_PER_US;
  localparam int unsigned ALIVE_CYC = ALIVE_US * CYC_PER_US;
  localparam int unsigned SYNC_PULSE_MIN_CYC = SYNC_PULSE_MIN_US * CYC_PER_US;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned MEAS_W = 16;
  localparam logic [MEAS_W-1:0] DETECT_THRESH = 16'h000a;
  localparam logic [MEAS_W-1:0] HYST_COUNTS = 16'h0002;
  localparam logic [2:0] CONFIRM_COUNT = 3'h4;
  localparam logic [MEAS_W-1:0] REF_RESET = 16'h0000;

  typedef enum logic [3:0] {
    TDS_ST_ALIVE = 4'h1,
    TDS_ST_BURST = 4'h2,
    TDS_ST_GAP = 4'h4,
    TDS_ST_SYNC_WAIT = 4'h8
  } tds_state_e;

  typedef enum logic [2:0] {
    TDS_MODE_FAST = 3'h1,
    TDS_MODE_SLEEPY = 3'h2,
    TDS_MODE_SYNC = 3'h4
  } tds_mode_e;

  typedef struct packed {
    logic valid;
    logic [MEAS_W-1:0] value;
  } tds_meas_s;

  typedef struct packed {
    logic level;
    logic drive_en;
  } tds_out_s;
endpackage
`default_nettype wire

/* File: src/tds_sequencer.sv */
// touch detect sequencer: burst scheduling, detection, drift and timeout
// Summary of operation
// - mode chosen only from level and activity on mode select pin
// - pin high: fast mode, next burst about 1 ms after previous
// - pin low: sleepy_scan, sleep about 80 ms after each burst
// - sleepy_scan uses fast spacing while a possible touch is resolving
// - pin sampled at burst end; low in fast mode enters sync mode
// - sync with pulses from 10 us up to 1 ms: burst only on falling edges
// - sync mode sleeps; a pin edge starts a new burst, only falling edges after short pulses
// - pin unchanged over 80 ms in sync: back to fast or sleepy
// - sync mode bypasses confirm counter, each hit detects at once
// - recalibration timeout counts bursts, scaling with burst spacing
// - detection when measurement exceeds reference by 10 counts
// - detection ends only two counts below the detect threshold
// - detection outlasting stuck touch timeout forces full recalibration
// - stuck touch timeout counted in bursts, not a free timer
// - confirm counter counts hits, output at four, miss clears it
// - full recalibration at power up and on timeout expiry
// - reference slews toward measurement; thresholds follow reference
// - drift tracking frozen while a detection is in effect
// - reference follows falling measurements faster than rising ones
// - output high during detection, low after timeout recalibration
// - output released to high impedance 15 us before each burst
`default_nettype none
module tds_sequencer #(
  parameter int unsigned FAST_GAP = tds_pkg::FAST_GAP_CYC,
  parameter int unsigned SLEEP_GAP = tds_pkg::SLEEP_GAP_CYC,
  parameter int unsigned STUCK_BURSTS = 750,
  parameter int unsigned UP_DIV = 64,
  parameter int unsigned DOWN_DIV = 4
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic mode_select_i,
  input wire tds_pkg::tds_meas_s meas_i,
  output logic burst_start_o,
  output tds_pkg::tds_out_s detect_o,
  output logic [2:0] run_mode_o
);
  localparam int unsigned STK_W = 16;
  localparam int unsigned DIV_W = 8;
  localparam logic [tds_pkg::MEAS_W-1:0] DROP_OFFSET = tds_pkg::DETECT_THRESH - tds_pkg::HYST_COUNTS;

  typedef struct packed {
    tds_pkg::tds_state_e st;
    tds_pkg::tds_mode_e mode;
    logic [tds_pkg::CNT_W-1:0] tmr;
    logic [tds_pkg::CNT_W-1:0] pin_age;
    logic [tds_pkg::CNT_W-1:0] hi_len;
    logic pin_prev;
    logic pulse_mode;
    logic [tds_pkg::MEAS_W-1:0] ref_lvl;
    logic calibrated;
    logic [2:0] confirm;
    logic detect;
    logic [STK_W-1:0] stuck;
    logic [DIV_W-1:0] drift_div;
    logic start;
    logic alive;
  } tds_state_s;

  typedef struct packed {
    logic [tds_pkg::MEAS_W-1:0] ref_lvl;
    logic [DIV_W-1:0] div;
  } tds_drift_s;

  localparam tds_state_s RESET_STATE = '{
    st: tds_pkg::TDS_ST_ALIVE,
    mode: tds_pkg::TDS_MODE_FAST,
    tmr: '0,
    pin_age: '0,
    hi_len: '0,
    pin_prev: 1'b1,
    pulse_mode: 1'b0,
    ref_lvl: tds_pkg::REF_RESET,
    calibrated: 1'b0,
    confirm: '0,
    detect: 1'b0,
    stuck: '0,
    drift_div: '0,
    start: 1'b0,
    alive: 1'b0
  };

  tds_state_s q_r;
  tds_state_s q_nxt;
  tds_drift_s drift;

  function automatic logic [tds_pkg::CNT_W-1:0] tds_gap(input int unsigned cyc);
    tds_gap = tds_pkg::CNT_W'(cyc);
  endfunction

  // true once a counter started at zero has covered span cycles
  function automatic logic tds_span_done(
    input logic [tds_pkg::CNT_W-1:0] cnt,
    input int unsigned span
  );
    logic [tds_pkg::CNT_W:0] last;
    last = {1'b0, tds_gap(span)} - {{tds_pkg::CNT_W{1'b0}}, 1'b1};
    tds_span_done = {1'b0, cnt} >= last;
  endfunction

  // guard bit keeps a reference near full scale from wrapping
  function automatic logic tds_reaches(
    input logic [tds_pkg::MEAS_W-1:0] meas,
    input logic [tds_pkg::MEAS_W-1:0] base,
    input logic [tds_pkg::MEAS_W-1:0] offset
  );
    logic [tds_pkg::MEAS_W:0] level;
    level = {1'b0, base} + {1'b0, offset};
    tds_reaches = {1'b0, meas} >= level;
  endfunction

  // slew limited step, downward after fewer bursts
  function automatic tds_drift_s tds_drift(
    input logic [tds_pkg::MEAS_W-1:0] meas,
    input logic [tds_pkg::MEAS_W-1:0] ref_lvl,
    input logic [DIV_W-1:0] div
  );
    tds_drift = '{ref_lvl: ref_lvl, div: div + 1'b1};
    if (meas < ref_lvl && div >= DIV_W'(DOWN_DIV - 1)) begin
      tds_drift.ref_lvl = ref_lvl - 1'b1;
      tds_drift.div = '0;
    end else if (meas > ref_lvl && div >= DIV_W'(UP_DIV - 1)) begin
      tds_drift.ref_lvl = ref_lvl + 1'b1;
      tds_drift.div = '0;
    end else if (meas == ref_lvl) begin
      tds_drift.div = '0;
    end
  endfunction

  // detection end or recalibration clears the touch counters
  function automatic tds_state_s tds_clear_touch(input tds_state_s s);
    tds_clear_touch = s;
    tds_clear_touch.detect = 1'b0;
    tds_clear_touch.stuck = '0;
    tds_clear_touch.confirm = '0;
  endfunction

  // spacing in force, fast while a touch resolves
  function automatic int unsigned tds_gap_span(
    input tds_pkg::tds_mode_e mode,
    input logic [2:0] confirm
  );
    if (mode == tds_pkg::TDS_MODE_FAST || confirm != 3'h0) begin
      tds_gap_span = FAST_GAP;
    end else begin
      tds_gap_span = SLEEP_GAP;
    end
  endfunction

  // mode taken from the pin sample at burst end
  function automatic tds_pkg::tds_mode_e tds_end_mode(
    input tds_pkg::tds_mode_e mode,
    input logic pin
  );
    tds_end_mode = mode;
    if (mode == tds_pkg::TDS_MODE_FAST && !pin) begin
      tds_end_mode = tds_pkg::TDS_MODE_SYNC;
    end else if (mode == tds_pkg::TDS_MODE_SLEEPY && pin) begin
      tds_end_mode = tds_pkg::TDS_MODE_FAST;
    end
  endfunction

  // high phase from minimum pulse width up to fast spacing
  function automatic logic tds_short_pulse(input logic [tds_pkg::CNT_W-1:0] len);
    tds_short_pulse = len >= tds_gap(tds_pkg::SYNC_PULSE_MIN_CYC) && len < tds_gap(FAST_GAP);
  endfunction

  logic above_thr;
  logic above_drop;
  logic [tds_pkg::MEAS_W-1:0] m;
  logic pin_edge;

  assign m = meas_i.value;
  assign pin_edge = mode_select_i != q_r.pin_prev;
  assign above_thr = tds_reaches(m, q_r.ref_lvl, tds_pkg::DETECT_THRESH);
  assign above_drop = tds_reaches(m, q_r.ref_lvl, DROP_OFFSET);

  always_comb begin
    q_nxt = q_r;
    drift = '0;
    q_nxt.start = 1'b0;
    q_nxt.pin_prev = mode_select_i;
    q_nxt.pin_age = pin_edge ? '0 : q_r.pin_age + 1'b1;
    if (mode_select_i) begin
      q_nxt.hi_len = q_r.hi_len + 1'b1;
    end else begin
      q_nxt.hi_len = '0;
    end
    case (q_r.st)
      tds_pkg::TDS_ST_ALIVE: begin
        q_nxt.alive = 1'b1;
        // counter runs one past the window so the release lasts the full span
        if (tds_span_done(q_r.tmr, tds_pkg::ALIVE_CYC + 1)) begin
          q_nxt.alive = 1'b0;
          q_nxt.st = tds_pkg::TDS_ST_BURST;
          q_nxt.start = 1'b1;
          q_nxt.tmr = '0;
        end else begin
          q_nxt.tmr = q_r.tmr + 1'b1;
        end
      end
      tds_pkg::TDS_ST_BURST: begin
        if (meas_i.valid) begin
          q_nxt.tmr = '0;
          if (!q_r.calibrated) begin
            q_nxt.ref_lvl = m;
            q_nxt.calibrated = 1'b1;
          end else if (q_r.detect) begin
            q_nxt.stuck = q_r.stuck + 1'b1;
            if (!above_drop) begin
              q_nxt = tds_clear_touch(q_nxt);
            end else if (q_r.stuck >= STK_W'(STUCK_BURSTS - 1)) begin
              q_nxt.ref_lvl = m;
              q_nxt = tds_clear_touch(q_nxt);
            end
          end else if (above_thr) begin
            if (q_r.mode == tds_pkg::TDS_MODE_SYNC || q_r.confirm == tds_pkg::CONFIRM_COUNT - 1) begin
              q_nxt.detect = 1'b1;
              q_nxt.confirm = '0;
            end else begin
              q_nxt.confirm = q_r.confirm + 1'b1;
            end
          end else begin
            q_nxt.confirm = '0;
            drift = tds_drift(m, q_r.ref_lvl, q_r.drift_div);
            q_nxt.ref_lvl = drift.ref_lvl;
            q_nxt.drift_div = drift.div;
          end
          q_nxt.mode = tds_end_mode(q_r.mode, mode_select_i);
          if (q_r.mode != tds_pkg::TDS_MODE_SYNC) begin
            q_nxt.pulse_mode = 1'b0;
          end
          q_nxt.st = (q_nxt.mode == tds_pkg::TDS_MODE_SYNC) ? tds_pkg::TDS_ST_SYNC_WAIT : tds_pkg::TDS_ST_GAP;
        end
      end
      tds_pkg::TDS_ST_GAP: begin
        q_nxt.tmr = q_r.tmr + 1'b1;
        // fast spacing in fast mode or while resolving, else sleepy spacing
        if (tds_span_done(q_r.tmr, tds_gap_span(q_r.mode, q_r.confirm))) begin
          q_nxt.st = tds_pkg::TDS_ST_ALIVE;
          q_nxt.tmr = '0;
        end
      end
      tds_pkg::TDS_ST_SYNC_WAIT: begin
        if (pin_edge) begin
          // short high pulses select falling edge only
          if (!mode_select_i && tds_short_pulse(q_r.hi_len)) begin
            q_nxt.pulse_mode = 1'b1;
          end
          if (!q_r.pulse_mode || !mode_select_i) begin
            q_nxt.st = tds_pkg::TDS_ST_ALIVE;
            q_nxt.tmr = '0;
          end
        end else if (tds_span_done(q_r.pin_age, SLEEP_GAP)) begin
          // sync timeout, mode by pin level
          q_nxt.mode = mode_select_i ? tds_pkg::TDS_MODE_FAST : tds_pkg::TDS_MODE_SLEEPY;
          q_nxt.st = tds_pkg::TDS_ST_ALIVE;
          q_nxt.tmr = '0;
        end
      end
      default: begin
        q_nxt.st = tds_pkg::TDS_ST_ALIVE;
        q_nxt.tmr = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r <= RESET_STATE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign burst_start_o = q_r.start;
  assign detect_o.level = q_r.detect;
  assign detect_o.drive_en = !q_r.alive;
  assign run_mode_o = q_r.mode;
endmodule
`default_nettype wire

/* File: tb/tds_front_end.sv */
// front end model: answers each burst with one result
`default_nettype none
module tds_front_end (
  input wire logic core_clk_i,
  input wire logic burst_i,
  input wire logic [15:0] value_i,
  output var tds_pkg::tds_meas_s meas_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial meas_o = '0;
  always @(posedge core_clk_i) begin
    if (burst_i) begin
      repeat (2 + $urandom % 30) @(negedge core_clk_i);
      meas_o <= '{1'b1, value_i};
      @(negedge core_clk_i);
      meas_o <= '{1'b0, ~value_i};
    end
  end
endmodule
`default_nettype wire

/* File: tb/tds_sequencer_asserts.sv */
// port assertions for the touch detect sequencer
`default_nettype none
module tds_sequencer_asserts #(
  parameter int unsigned FAST_GAP = 50
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic mode_select_i,
  input wire tds_pkg::tds_meas_s meas_i,
  input wire logic burst_start_o,
  input wire tds_pkg::tds_out_s detect_o,
  input wire logic [2:0] run_mode_o
);
  localparam int GLO = FAST_GAP - 5;
  localparam int GHI = FAST_GAP + 10;
  logic [8:0] low_r;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) low_r <= 9'h000;
    else low_r <= detect_o.drive_en ? 9'h000 : low_r + 9'h001;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_alive_width: assert property ($rose(detect_o.drive_en) |-> low_r == 9'h12c)
    else $error("alive width wrong");
  a_alive_burst: assert property ($rose(detect_o.drive_en) |-> burst_start_o)
    else $error("no burst after alive");
  a_burst_alive: assert property (burst_start_o |-> !$past(detect_o.drive_en))
    else $error("burst without alive");
  a_mode_onehot: assert property ($onehot(run_mode_o))
    else $error("mode not one-hot");
  a_detect_cause: assert property ($changed(detect_o.level) |-> $past(meas_i.valid) || $past(meas_i.valid, 2))
    else $error("detect moved without result");
  a_fast_gap: assert property (meas_i.valid && mode_select_i && run_mode_o == 3'h1 |-> ##[GLO:GHI] $fell(detect_o.drive_en))
    else $error("fast gap wrong");
  a_reset_state: assert property ($rose(rstn_i) |-> !detect_o.level && run_mode_o == 3'h1)
    else $error("reset state wrong");
  a_sync_wake: assert property (run_mode_o == 3'h4 && $changed(mode_select_i) && detect_o.drive_en |-> ##[1:8] !detect_o.drive_en)
    else $error("sync edge ignored");
  c_confirm: cover property ($rose(detect_o.level));
  c_sync: cover property ($rose(run_mode_o[2]));
  c_sleepy: cover property ($rose(run_mode_o[1]));
endmodule
bind tds_sequencer tds_sequencer_asserts #(.FAST_GAP(FAST_GAP)) u_asserts (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .mode_select_i(mode_select_i), .meas_i(meas_i),
  .burst_start_o(burst_start_o), .detect_o(detect_o), .run_mode_o(run_mode_o));
`default_nettype wire

/* File: tb/tds_sequencer_test.sv */
// self-checking bench for the touch detect sequencer
`default_nettype none
`define CMP(g, x) begin n_compared++; if ((g) !== (x)) begin miscompares++; \
  $display("wrong value at %0t: %h vs %h", $time, g, x); end end
module tds_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b1;
  logic [15:0] val = 16'h0100;
  logic burst;
  logic [2:0] run;
  logic [1:0] e;
  logic [1:0] q[$];
  logic [0:21] ex = 22'b0000000110_0001_111100_00;
  logic [0:21] cr = 22'b1111111111_1111_111111_11;
  logic [15:0] va[10] = '{16'h010a, 16'h010a, 16'h010a, 16'h0100, 16'h010a,
    16'h010a, 16'h010a, 16'h010a, 16'h0108, 16'h0107};
  tds_pkg::tds_meas_s meas;
  tds_pkg::tds_out_s det;
  int miscompares = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  tds_sequencer #(.FAST_GAP(50), .SLEEP_GAP(400), .STUCK_BURSTS(5)) u_dut (.core_clk_i(clk), .rstn_i(rst_n),
    .mode_select_i(mode), .meas_i(meas), .burst_start_o(burst), .detect_o(det), .run_mode_o(run));
  tds_front_end u_afe (.core_clk_i(clk), .burst_i(burst), .value_i(val), .meas_o(meas));
  task automatic complete_run;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits for a burst, sets its result and notes the expected level
  task automatic hit(input logic [15:0] v, input logic [1:0] x);
    int n = 0;
    while (burst !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n == 40000) miscompares++;
    val = v;
    q.push_back(x);
    @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (meas.valid === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      repeat (2) @(negedge clk);
      if (e[1]) `CMP(det.level, e[0])
    end
  end
  initial begin
    void'($urandom(45683));
    repeat (16) @(negedge clk);
    `CMP(det, 2'b01)
    rst_n = 1'b1;
    hit(16'h0100, 2'b10);
    repeat (6) hit(16'h0100 + 16'($urandom % 8), 2'b10);
    for (int i = 0; i < 22; i++) hit(i < 10 ? va[i] : 16'h010a, {cr[i], ex[i]});
    repeat (21000) @(negedge clk);
    hit(16'h010a, 2'b00);
    // pin held low past the burst
    mode = 1'b0;
    repeat (200) @(negedge clk);
    `CMP(run, 3'h4)
    mode = 1'b1;
    hit(16'h0114, 2'b11);
    repeat (1500) @(negedge clk);
    `CMP(run, 3'h1)
    mode = 1'b0;
    repeat (1500) @(negedge clk);
    `CMP(run, 3'h2)
    complete_run();
  end
  initial begin
    #5ms;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
